// ==== inc/rcsb_pkg.sv ====
// Constants and types shared by the radio configuration and strobe bank.
package rcsb_pkg;
	// ------------------------------------------------------------------
	// Widths.
	// ------------------------------------------------------------------
	localparam int ADDR_W   = 6;
	localparam int BYTE_W   = 8;
	localparam int DATA_W   = 16;
	localparam int BUF_DEPTH = 2;
	// ------------------------------------------------------------------
	// Address byte layout and address map.
	// ------------------------------------------------------------------
	localparam int ADDR_RAM_BIT  = 7;
	localparam int ADDR_READ_BIT = 6;
	localparam logic [5:0] CMD_NOOP      = 6'h00;
	localparam logic [5:0] CMD_OSC_ON    = 6'h01;
	localparam logic [5:0] CMD_SYNTH_CAL = 6'h02;
	localparam logic [5:0] CMD_RX_ON     = 6'h03;
	localparam logic [5:0] CMD_TX_ON     = 6'h04;
	localparam logic [5:0] CMD_TX_CLEAR  = 6'h05;
	localparam logic [5:0] CMD_RF_OFF    = 6'h06;
	localparam logic [5:0] CMD_OSC_OFF   = 6'h07;
	localparam logic [5:0] CMD_RX_FLUSH  = 6'h08;
	localparam logic [5:0] CMD_TX_FLUSH  = 6'h09;
	localparam logic [5:0] CMD_ACK       = 6'h0a;
	localparam logic [5:0] CMD_ACK_PEND  = 6'h0b;
	localparam logic [5:0] CMD_RX_DEC    = 6'h0c;
	localparam logic [5:0] CMD_TX_ENC    = 6'h0d;
	localparam logic [5:0] CMD_AES       = 6'h0e;
	localparam logic [5:0] CFG_FIRST     = 6'h10;
	localparam logic [5:0] CFG_LAST      = 6'h30;
	localparam logic [5:0] SEC_CTRL_ADDR = 6'h19;
	localparam logic [5:0] FSM_VIEW_ADDR = 6'h2c;
	localparam logic [5:0] TX_PORT_ADDR  = 6'h3e;
	localparam logic [5:0] RX_PORT_ADDR  = 6'h3f;
	localparam int CFG_COUNT = 33;
	// ------------------------------------------------------------------
	// Fields and reset values.
	// ------------------------------------------------------------------
	localparam int SOFT_RESET_BIT = 15;
	localparam int SEC_MODE_LSB   = 0;
	localparam int SEC_MODE_W     = 2;
	localparam logic [15:0] MAIN_RESET_VAL = 16'h8000;
	localparam logic [15:0] CFG_RESET_VAL  = 16'h0000;
	localparam logic [2:0]  LAST_BIT       = 3'h7;
	// ------------------------------------------------------------------
	// Status byte bit positions.
	// ------------------------------------------------------------------
	localparam int ST_OSC_RUN = 6;
	localparam int ST_TX_OVF  = 5;
	localparam int ST_ENC_BSY = 4;
	localparam int ST_TX_ON   = 3;
	localparam int ST_SYNTH   = 2;
	localparam int ST_RX_ON   = 1;
	// ------------------------------------------------------------------
	// Serial transfer phase, one-hot.
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		SP_IDLE = 4'b0001,
		SP_ADDR = 4'b0010,
		SP_DATA = 4'b0100,
		SP_SKIP = 4'b1000
	} rcsb_phase_t;
endpackage

// ==== verilog/rcsb_bank.sv ====
// Serial register bank and command strobe decoder of the packet radio.
`timescale 1ns/1ps
module rcsb_bank
	import rcsb_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic                  SCLK,
	input  wire logic                  CSN,
	input  wire logic                  SI,
	output logic                       SO,
	output logic                       SO_OE,
	input  wire logic                  CCA,
	input  wire logic                  ENC_IDLE,
	input  wire logic [BYTE_W-1:0]     RX_BYTE,
	output logic                       RX_POP,
	output logic [BYTE_W-1:0]          TX_DATA,
	output logic                       TX_VALID,
	input  wire logic                  TX_READY,
	output logic                       OSC_PD,
	output logic                       BIAS_POWERDOWN,
	output logic                       SYNTH_ON,
	output logic                       SYNTH_CAL,
	output logic                       RX_ON,
	output logic                       TX_ON,
	output logic                       RX_FLUSH,
	output logic                       TX_FLUSH,
	output logic                       ACK_SEND,
	output logic                       ACK_PENDING,
	output logic                       RX_DECRYPT,
	output logic                       TX_ENCRYPT,
	output logic                       AES_START,
	output logic [SEC_MODE_W-1:0]      SEC_MODE
);
	// ------------------------------------------------------------------
	// Helper functions.
	// ------------------------------------------------------------------
	// True for an address inside the configuration window.
	function automatic logic in_cfg(input logic [5:0] a);
		in_cfg = (a >= CFG_FIRST) && (a <= CFG_LAST);
	endfunction

	// True for a command strobe address.
	function automatic logic is_strobe(input logic [5:0] a);
		is_strobe = (a <= CMD_AES);
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------------
	logic [2:0]  s1_reg;       // First stage: SI, CSN, SCLK.
	logic [2:0]  s2_reg;       // Second stage.
	logic [2:0]  s3_reg;       // Third stage.
	logic [2:0]  filt_reg;     // Accepted pin levels.
	logic [2:0]  filt_next;    // Level accepted when stages two and three agree.
	logic        sclk_rise;    // Serial clock rising edge seen.
	logic        sclk_fall;    // Serial clock falling edge seen.
	logic        csn_fall;     // Chip select asserted.
	logic        csn_high;     // Chip select released.
	logic        si_val;       // Serial data level.

	assign filt_next = (s2_reg ~^ s3_reg) & s3_reg | ~(s2_reg ^~ s3_reg) & filt_reg;
	assign sclk_rise = filt_next[0] & ~filt_reg[0];
	assign sclk_fall = ~filt_next[0] & filt_reg[0];
	assign csn_fall  = ~filt_next[1] & filt_reg[1];
	assign csn_high  = filt_next[1];
	assign si_val    = filt_next[2];

	// Shift the pins through three stages and keep the agreed level.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			s1_reg   <= 3'h2;
			s2_reg   <= 3'h2;
			s3_reg   <= 3'h2;
			filt_reg <= 3'h2;
		end
		else
		begin
			s1_reg   <= {SI, CSN, SCLK};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	// ------------------------------------------------------------------
	// Serial byte framing.
	// ------------------------------------------------------------------
	rcsb_phase_t      phase_reg;   // Transfer phase.
	logic [2:0]       bit_reg;     // Bit index within the byte.
	logic [1:0]       byte_reg;    // Data byte index, saturating.
	logic [7:0]       sh_reg;      // Input shift register.
	logic [7:0]       addr_reg;    // Latched address byte.
	logic [7:0]       hi_reg;      // Upper data byte of a write.
	logic [7:0]       lo_reg;      // Lower byte kept for a read.
	logic             byte_done;   // Last bit of a byte sampled.
	logic [7:0]       byte_val;    // Completed byte.
	logic             addr_done;   // Address byte completed.
	logic             data_done;   // Data byte completed.
	logic [5:0]       a_now;       // Address of the byte being completed.
	logic [5:0]       a_cur;       // Address of the transfer.
	logic             rd_now;      // Read bit of the address byte.
	logic             ram_now;     // RAM access bit of the address byte.

	assign byte_done = sclk_rise & (bit_reg == LAST_BIT) & (phase_reg != SP_IDLE);
	assign byte_val  = {sh_reg[6:0], si_val};
	assign addr_done = byte_done & (phase_reg == SP_ADDR);
	assign data_done = byte_done & (phase_reg == SP_DATA);
	assign a_now     = byte_val[ADDR_W-1:0];
	assign rd_now    = byte_val[ADDR_READ_BIT];
	assign ram_now   = byte_val[ADDR_RAM_BIT];
	assign a_cur     = addr_reg[ADDR_W-1:0];

	// Count bits and bytes; strobes skip any further bytes.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			phase_reg <= SP_IDLE;
			bit_reg   <= 3'h0;
			byte_reg  <= 2'h0;
			sh_reg    <= 8'h00;
			addr_reg  <= 8'h00;
			hi_reg    <= 8'h00;
		end
		else if (csn_high)
			phase_reg <= SP_IDLE;
		else if (csn_fall)
		begin
			phase_reg <= SP_ADDR;
			bit_reg   <= 3'h0;
			byte_reg  <= 2'h0;
		end
		else if (sclk_rise && phase_reg != SP_IDLE)
		begin
			sh_reg  <= byte_val;
			bit_reg <= bit_reg + 3'h1;
			case (phase_reg)
				SP_ADDR:
				begin
					if (byte_done)
					begin
						addr_reg  <= byte_val;
						// A strobe needs no data bytes; RAM access is not served.
						phase_reg <= (is_strobe(a_now) || ram_now) ? SP_SKIP : SP_DATA;
					end
				end
				SP_DATA:
				begin
					if (byte_done)
					begin
						hi_reg   <= (byte_reg == 2'h0) ? byte_val : hi_reg;
						byte_reg <= (byte_reg == 2'h3) ? byte_reg : byte_reg + 2'h1;
					end
				end
				SP_SKIP:
					phase_reg <= SP_SKIP;
				default:
					phase_reg <= SP_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers.
	// ------------------------------------------------------------------
	logic [15:0]      main_reg;                  // Main control, pin reset only.
	logic [15:0]      cfg_mem [1:CFG_COUNT-1];   // Remaining configuration words.
	logic             soft_rst;                  // Chip reset held by the main bit.
	logic             cfg_wr;                    // Second data byte of a write.
	logic [15:0]      wr_word;                   // Word being written.
	logic [5:0]       idx_cur;                   // Array index of the transfer.
	logic [5:0]       idx_now;                   // Array index of a fresh address.
	logic [15:0]      fsm_view;                  // Radio state read back.
	logic [15:0]      rd_word;                   // Word read at a fresh address.

	assign soft_rst = ~main_reg[SOFT_RESET_BIT];
	assign cfg_wr   = data_done & (byte_reg == 2'h1) & ~addr_reg[ADDR_READ_BIT] & in_cfg(a_cur);
	assign wr_word  = {hi_reg, byte_val};
	assign idx_cur  = a_cur - CFG_FIRST;
	assign idx_now  = a_now - CFG_FIRST;
	assign rd_word  = !in_cfg(a_now) ? 16'h0000 :
		(a_now == CFG_FIRST) ? main_reg :
		(a_now == FSM_VIEW_ADDR) ? fsm_view : cfg_mem[idx_now];

	// Main control stores exactly what is written and ignores soft reset.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			main_reg <= MAIN_RESET_VAL;
		else if (cfg_wr && a_cur == CFG_FIRST)
			main_reg <= wr_word;
	end

	// The other words return to defaults on either reset.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 1; i < CFG_COUNT; i++)
				cfg_mem[i] <= CFG_RESET_VAL;
		end
		else if (soft_rst)
		begin
			// The soft reset acts on the clock, so only the pin is asynchronous.
			for (int i = 1; i < CFG_COUNT; i++)
				cfg_mem[i] <= CFG_RESET_VAL;
		end
		else if (cfg_wr && a_cur != CFG_FIRST && a_cur != FSM_VIEW_ADDR)
			cfg_mem[idx_cur] <= wr_word;
	end

	assign SEC_MODE = cfg_mem[SEC_CTRL_ADDR-CFG_FIRST][SEC_MODE_LSB+:SEC_MODE_W];

	// ------------------------------------------------------------------
	// Strobe decoding and radio control.
	// ------------------------------------------------------------------
	logic        osc_pd_reg, bias_powerdown_reg, synth_reg, rx_reg, tx_reg;
	logic        cal_done_reg;   // Synthesizer already calibrated.
	logic        cal_reg;        // Calibration pulse.
	logic        rxf_reg;        // Receive flush pulse.
	logic        txf_reg;        // Transmit flush pulse.
	logic        ack_reg;        // Acknowledge send pulse.
	logic        pend_reg;       // Pending field of the acknowledge.
	logic        dec_reg;        // Inline decryption pulse.
	logic        enc_reg;        // Inline encryption pulse.
	logic        aes_reg;        // Stand-alone encryption pulse.
	logic        hit;            // A strobe address arrived.
	logic        sec_on;         // Inline security selected.
	logic        go_tx;          // Transmit strobe takes effect.
	logic        cal_now;        // Calibration wanted by a strobe.

	assign hit     = addr_done & ~ram_now & is_strobe(a_now);
	assign sec_on  = (SEC_MODE != '0);
	assign go_tx   = hit & ((a_now == CMD_TX_ON) | (a_now == CMD_TX_CLEAR) & CCA);
	assign cal_now = hit & (a_now == CMD_SYNTH_CAL) |
		go_tx & ((a_now == CMD_TX_CLEAR) | ~cal_done_reg);
	assign fsm_view = {10'h000, cal_done_reg, tx_reg, rx_reg, synth_reg, bias_powerdown_reg, osc_pd_reg};

	// Radio level controls; the noop strobe falls to the default branch.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			osc_pd_reg   <= 1'b1;
			bias_powerdown_reg  <= 1'b1;
			synth_reg    <= 1'b0;
			rx_reg       <= 1'b0;
			tx_reg       <= 1'b0;
			cal_done_reg <= 1'b0;
		end
		else if (soft_rst)
		begin
			// Soft reset holds the radio at its defaults on the clock.
			osc_pd_reg   <= 1'b1;
			bias_powerdown_reg  <= 1'b1;
			synth_reg    <= 1'b0;
			rx_reg       <= 1'b0;
			tx_reg       <= 1'b0;
			cal_done_reg <= 1'b0;
		end
		else if (hit)
		begin
			cal_done_reg <= cal_done_reg | cal_now;
			case (a_now)
				CMD_OSC_ON:
				begin
					osc_pd_reg  <= 1'b0;
					bias_powerdown_reg <= 1'b0;
				end
				CMD_SYNTH_CAL:
				begin
					synth_reg <= 1'b1;
					rx_reg    <= 1'b0;
					tx_reg    <= 1'b0;
				end
				CMD_RX_ON:
				begin
					synth_reg <= 1'b1;
					rx_reg    <= 1'b1;
					tx_reg    <= 1'b0;
				end
				CMD_TX_ON, CMD_TX_CLEAR:
				begin
					// A busy channel leaves the radio as it was.
					synth_reg <= synth_reg | go_tx;
					tx_reg    <= tx_reg | go_tx;
					rx_reg    <= rx_reg & ~go_tx;
				end
				CMD_RF_OFF:
				begin
					{synth_reg, rx_reg, tx_reg} <= 3'h0;
					cal_done_reg <= 1'b0;
				end
				CMD_OSC_OFF:
				begin
					{synth_reg, rx_reg, tx_reg} <= 3'h0;
					{osc_pd_reg, bias_powerdown_reg} <= 2'h3;
					cal_done_reg <= 1'b0;
				end
				default:
					osc_pd_reg <= osc_pd_reg;
			endcase
		end
	end

	// One-cycle command pulses and the held pending field for the radio datapath.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			{cal_reg, rxf_reg, txf_reg, ack_reg} <= 4'h0;
			{pend_reg, dec_reg, enc_reg, aes_reg} <= 4'h0;
		end
		else if (soft_rst)
		begin
			// No command pulse leaves the bank while soft reset is held.
			{cal_reg, rxf_reg, txf_reg, ack_reg} <= 4'h0;
			{pend_reg, dec_reg, enc_reg, aes_reg} <= 4'h0;
		end
		else
		begin
			cal_reg  <= cal_now;
			rxf_reg  <= hit & (a_now == CMD_RX_FLUSH);
			txf_reg  <= hit & (a_now == CMD_TX_FLUSH);
			ack_reg  <= hit & ((a_now == CMD_ACK) | (a_now == CMD_ACK_PEND));
			pend_reg <= (hit & (a_now == CMD_ACK)) ? 1'b0 :
				(hit & (a_now == CMD_ACK_PEND)) ? 1'b1 : pend_reg;
			dec_reg  <= hit & (a_now == CMD_RX_DEC) & sec_on;
			enc_reg  <= hit & (a_now == CMD_TX_ENC) & sec_on | go_tx & sec_on;
			aes_reg  <= hit & (a_now == CMD_AES) & ENC_IDLE;
		end
	end

	assign {OSC_PD, BIAS_POWERDOWN, SYNTH_ON, RX_ON, TX_ON} =
		{osc_pd_reg, bias_powerdown_reg, synth_reg, rx_reg, tx_reg};
	assign {SYNTH_CAL, RX_FLUSH, TX_FLUSH, ACK_SEND} = {cal_reg, rxf_reg, txf_reg, ack_reg};
	assign {ACK_PENDING, RX_DECRYPT, TX_ENCRYPT, AES_START} = {pend_reg, dec_reg, enc_reg, aes_reg};

	// ------------------------------------------------------------------
	// Transmit byte buffer, two entries.
	// ------------------------------------------------------------------
	logic [7:0]  head_reg;    // Oldest byte, offered downstream.
	logic [7:0]  tail_reg;    // Second byte.
	logic [1:0]  cnt_reg;     // Entries held.
	logic [1:0]  cnt_next;    // Entries after this cycle.
	logic        valid_reg;   // Downstream valid.
	logic        ovf_reg;     // A byte arrived with no room.
	logic        push_req;    // Byte written to the transmit port.
	logic        pop;         // Downstream took the head.
	logic        room;        // Filling side ready.
	logic        push;        // Byte accepted.

	// Writes only; the port never feeds data back out.
	assign push_req = data_done & (a_cur == TX_PORT_ADDR) & ~addr_reg[ADDR_READ_BIT] &
		~osc_pd_reg;
	assign pop      = valid_reg & TX_READY;
	assign room     = (cnt_reg < 2'(BUF_DEPTH)) | pop;
	assign push     = push_req & room;
	assign cnt_next = txf_reg ? 2'h0 : cnt_reg + 2'(push) - 2'(pop);

	// Keep order, head first, and drop a byte that meets a full buffer.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			{head_reg, tail_reg} <= 16'h0000;
			cnt_reg   <= 2'h0;
			valid_reg <= 1'b0;
			ovf_reg   <= 1'b0;
		end
		else
		begin
			cnt_reg   <= cnt_next;
			valid_reg <= (cnt_next != 2'h0);
			// A new overflow wins over the flush that clears the flag.
			ovf_reg   <= (push_req & ~room) | (ovf_reg & ~txf_reg);
			if (pop && cnt_reg == 2'h2)
				head_reg <= tail_reg;
			if (push && (cnt_reg == 2'h0 || (pop && cnt_reg == 2'h1)))
				head_reg <= byte_val;
			else if (push)
				tail_reg <= byte_val;
		end
	end

	assign TX_DATA  = head_reg;
	assign TX_VALID = valid_reg;

	// ------------------------------------------------------------------
	// Serial output.
	// ------------------------------------------------------------------
	logic [7:0]  out_reg;     // Output shift register.
	logic        so_reg;      // Serial data output.
	logic        oe_reg;      // Output driven while selected.
	logic        hold_reg;    // Keep the fresh MSB over one falling edge.
	logic        pop_reg;     // Receive byte taken.
	logic [7:0]  status;      // Status byte.
	logic        rx_rd;       // Receive port read byte boundary.
	logic        load;        // New byte to present.
	logic [7:0]  load_val;    // Byte presented next.

	assign status = {1'b0, ~osc_pd_reg, ovf_reg, ~ENC_IDLE, tx_reg, synth_reg, rx_reg, 1'b0};
	assign rx_rd  = (addr_done & (a_now == RX_PORT_ADDR) & rd_now & ~ram_now |
		data_done & (a_cur == RX_PORT_ADDR) & addr_reg[ADDR_READ_BIT]) & ~osc_pd_reg;
	assign load   = csn_fall | addr_done | data_done;
	assign load_val = csn_fall ? status :
		rx_rd ? RX_BYTE :
		(addr_done & rd_now & ~ram_now) ? rd_word[15:8] :
		(data_done & addr_reg[ADDR_READ_BIT] & (byte_reg == 2'h0)) ? lo_reg :
		((addr_done ? a_now : a_cur) == TX_PORT_ADDR) ? status : 8'h00;

	// Present a byte at each boundary and shift after falling edges.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			{out_reg, lo_reg} <= 16'h0000;
			{so_reg, oe_reg, hold_reg, pop_reg} <= 4'h0;
		end
		else
		begin
			oe_reg  <= ~csn_high;
			pop_reg <= rx_rd;
			lo_reg  <= addr_done ? rd_word[7:0] : lo_reg;
			if (load)
			begin
				out_reg  <= load_val;
				so_reg   <= load_val[7];
				hold_reg <= ~csn_fall;
			end
			else if (sclk_fall && !hold_reg)
			begin
				out_reg <= {out_reg[6:0], 1'b0};
				so_reg  <= out_reg[6];
			end
			else if (sclk_fall)
				hold_reg <= 1'b0;
		end
	end

	assign SO     = so_reg;
	assign SO_OE  = oe_reg;
	assign RX_POP = pop_reg;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	noop_keeps_state_a: assert property (hit && a_now == CMD_NOOP |=> $stable(fsm_view))
		else $error("noop strobe changed radio state");
	osc_start_a: assert property (hit && a_now == CMD_OSC_ON && !soft_rst |=> !OSC_PD && !BIAS_POWERDOWN)
		else $error("oscillator strobe left a power-down set");
	synth_wait_a: assert property (hit && a_now == CMD_SYNTH_CAL && !soft_rst
		|=> SYNTH_ON && !RX_ON && !TX_ON && SYNTH_CAL)
		else $error("calibrate strobe did not reach synthesizer wait");
	rf_off_a: assert property (hit && a_now == CMD_RF_OFF |=> !RX_ON && !TX_ON && !SYNTH_ON)
		else $error("radio still on after off strobe");
	tx_encrypt_a: assert property (go_tx && sec_on && !soft_rst |=> TX_ON && TX_ENCRYPT)
		else $error("transmit strobe missed inline encryption");
	busy_channel_a: assert property (hit && a_now == CMD_TX_CLEAR && !CCA
		|=> $stable(TX_ON) && !SYNTH_CAL)
		else $error("busy channel still started transmit");
	osc_stop_a: assert property (hit && a_now == CMD_OSC_OFF |=> OSC_PD && BIAS_POWERDOWN && !SYNTH_ON)
		else $error("oscillator still running after stop");
	tx_flush_a: assert property (hit && a_now == CMD_TX_FLUSH && !soft_rst
		|=> TX_FLUSH ##1 !TX_VALID)
		else $error("transmit buffer not emptied by flush");
	ack_pend_a: assert property (hit && a_now == CMD_ACK_PEND && !soft_rst
		|=> ACK_SEND && ACK_PENDING ##1 !ACK_SEND)
		else $error("pending acknowledge not sent once");
	aes_idle_a: assert property (hit && a_now == CMD_AES && !ENC_IDLE |=> !AES_START)
		else $error("stand-alone encryption started while busy");
	main_keep_a: assert property (soft_rst && !(cfg_wr && a_cur == CFG_FIRST)
		|=> $stable(main_reg))
		else $error("soft reset disturbed main control");
	soft_default_a: assert property (soft_rst |=> SEC_MODE == '0 && OSC_PD)
		else $error("soft reset left a non-default value");
	status_out_a: assert property (csn_fall |=> SO == $past(status[7]) && out_reg == $past(status))
		else $error("status byte not presented at select");

	strobe_seen_c: cover property (hit && a_now == CMD_TX_ON ##1 TX_ON);
	buffer_full_c: cover property (cnt_reg == 2'h2 && !TX_READY);
	cfg_write_c: cover property (cfg_wr && a_cur == SEC_CTRL_ADDR);
	soft_reset_c: cover property (soft_rst ##1 !soft_rst);
endmodule

// ==== verification/rcsb_host.sv ====
// Host model: serial master that talks to the radio bank.
`timescale 1ns/1ps
module rcsb_host (
	output logic        SCLK,
	output logic        CSN,
	output logic        SI,
	input  wire logic   SO,
	output logic [15:0] RDATA,
	output logic        DONE
);
	// One transfer: address byte, then n data bytes, mode 0, 64 ns per bit.
	task automatic xfer(input logic [7:0] a, input int n, input logic [15:0] wd);
		logic [23:0] sh;
		sh = {a, wd};
		RDATA = 16'h0;
		CSN = 1'b0;
		#100;
		for (int i = 0; i < 8 + 8 * n; i++)
		begin
			SI = sh[23];
			sh = sh << 1;
			#32 SCLK = 1'b1;
			RDATA = {RDATA[14:0], SO};
			#32 SCLK = 1'b0;
		end
		#40 CSN = 1'b1;
		SI = ~SI;
		DONE = 1'b1;
		#20 DONE = 1'b0;
	endtask
	initial
	begin
		{SCLK, CSN, SI, DONE, RDATA} = {3'h2, 1'h0, 16'h0};
	end
endmodule

// ==== verification/rcsb_bank_tb.sv ====
// Self-checking bench of the radio configuration and strobe bank.
`timescale 1ns/1ps
module rcsb_bank_tb import rcsb_pkg::*; ;
	logic        CLK, RST, CCA, ENC_IDLE, TX_READY;
	logic [7:0]  RX_BYTE;
	wire         SCLK, CSN, SI, SO, DONE, TX_VALID, ACK_PENDING, RX_POP;
	wire  [7:0]  TX_DATA;
	wire  [15:0] RDATA;
	wire  [1:0]  SEC_MODE;
	logic [15:0] exp_q[$];
	logic [15:0] w;
	int          err_total, compares, cyc, pops;
	rcsb_host i_host (.SCLK(SCLK), .CSN(CSN), .SI(SI), .SO(SO), .RDATA(RDATA), .DONE(DONE));
	rcsb_bank i_dut (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CSN(CSN), .SI(SI), .SO(SO), .SO_OE(),
		.CCA(CCA), .ENC_IDLE(ENC_IDLE), .RX_BYTE(RX_BYTE), .RX_POP(RX_POP), .TX_DATA(TX_DATA),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY), .OSC_PD(), .BIAS_POWERDOWN(), .SYNTH_ON(),
		.SYNTH_CAL(), .RX_ON(), .TX_ON(), .RX_FLUSH(), .TX_FLUSH(), .ACK_SEND(),
		.ACK_PENDING(ACK_PENDING), .RX_DECRYPT(), .TX_ENCRYPT(), .AES_START(),
		.SEC_MODE(SEC_MODE));
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("Compares %0d, errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input int n, input logic [15:0] wd);
		i_host.xfer(a, n, wd);
		#40;
	endtask
	// Notes the expected answer, then runs the transfer.
	task automatic op(input logic [7:0] a, input int n, input logic [15:0] exp);
		exp_q.push_back(exp);
		wr(a, n, 16'h0);
	endtask
	// Watcher: each finished transfer with a note pending is compared.
	always @(posedge DONE)
		if (exp_q.size() > 0)
			chk(RDATA, exp_q.pop_front());
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// Hang guard: fails and stops after 30000 clock cycles.
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	// Random channel state, and a count of receive bytes taken, off the clock edge.
	always @(negedge CLK)
	begin
		CCA <= 1'($urandom);
		if (RX_POP === 1'b1)
			pops++;
	end
	initial
	begin
		{RST, CCA, ENC_IDLE, TX_READY, RX_BYTE} = {4'ha, 8'h0};
		w = 16'($urandom(87134));
		repeat (3) @(posedge CLK);
		@(negedge CLK) RST = 1'b0;
		op(8'h6c, 2, 16'h0003);
		wr(8'h01, 0, 0);
		op(8'h00, 0, 16'h0040);
		w = 16'($urandom);
		wr(8'h11, 2, w);
		op(8'h51, 2, w);
		wr(8'h19, 2, 16'h0001);
		chk({14'h0, SEC_MODE}, 16'h0001);
		wr(8'h04, 0, 0);
		op(8'h6c, 2, 16'h0034);
		wr(8'h03, 0, 0);
		op(8'h6c, 2, 16'h002c);
		wr(8'h06, 0, 0);
		op(8'h6c, 2, 16'h0000);
		wr(8'h3e, 2, 16'ha55a);
		op(8'h3e, 1, 16'h4040);
		op(8'h00, 0, 16'h0060);
		chk({15'h0, TX_VALID}, 16'h0001);
		chk({8'h0, TX_DATA}, 16'h00a5);
		wr(8'h09, 0, 0);
		op(8'h00, 0, 16'h0040);
		chk({15'h0, TX_VALID}, 16'h0000);
		@(negedge CLK)
		begin
			TX_READY = 1'b1;
			RX_BYTE  = 8'($urandom);
		end
		op(8'h7f, 1, {8'h40, RX_BYTE});
		chk(16'(pops), 16'h0002);
		wr(8'h10, 2, 16'h1234);
		op(8'h50, 2, 16'h1234);
		wr(8'h10, 2, 16'h8000);
		op(8'h51, 2, 16'h0000);
		for (int c = 0; c < 15; c++)
		begin
			// The stand-alone encryption strobe meets a busy engine.
			if (c == 14)
				@(negedge CLK) ENC_IDLE = 1'b0;
			wr(8'(c), 0, 0);
			if (c == 10)
				chk({15'h0, ACK_PENDING}, 16'h0000);
		end
		chk({15'h0, ACK_PENDING}, 16'h0001);
		op(8'h6c, 2, 16'h0003);
		wr(8'h31, 2, 16'hffff);
		op(8'h71, 2, 16'h0000);
		tally_and_finish();
	end
endmodule
